// *** src/timer0_capture_compare_regs.sv ***
// Timer/counter with capture, compare and byte register access
// Summary of operation
// R01 - Width bit selects 16-bit count and merges both compare bytes.
// R02 - Capture mode bit turns compare registers into the capture register.
// R03 - Noise filter changes output after four equal successive samples.
// R04 - Edge select: zero falling edge, one rising edge.
// R05 - Capture trigger copies count into capture register and sets capture flag.
// R06 - Comparator source bit routes comparator into the same capture front end.
// R07 - Software sets capture interrupt enable for comparator-driven interrupts.
// R08 - Control bits two and one read as zero.
// R09 - Clear-on-match bit selects free counting or clear on compare match.
// R10 - Count low byte gives direct access; low half in 16-bit mode.
// R11 - Writing the count blocks compare matches for the next timer tick.
// R12 - Sixteen-bit accesses go through one shared high-byte holding register.
// R13 - Compare A matches count low byte; low compare byte in 16-bit mode.
// R14 - Compare B matches low byte in 8-bit; high compare byte in 16-bit.
// R15 - Compare A interrupt needs enable, global flag and compare A flag.
// R16 - Compare B interrupt needs enable, global flag and compare B flag.
// R17 - Wrap interrupt needs enable, global flag and wrap flag.
// R18 - Capture interrupt needs enable, global flag and capture flag.
// R19 - Flags clear on vector acknowledge or by writing one.
// R20 - Low byte access triggers transfer; write high first, read low first.
// R21 - Compare flag sets one timer tick after the count equals compare.
// R22 - Compare value reads directly; capture value reads through holding register.
// R23 - Clear-on-match clears count after match; normal wraps and sets wrap flag.
`timescale 1ns/10ps
`default_nettype none
module timer0_capture_compare_regs (
   input wire logic clk,
   input wire logic rst,
   input wire timer0_pkg::cpu_access_t cpu,
   output logic [7:0] rdata,
   input wire logic timer_tick,
   input wire logic global_irq_enable,
   input wire timer0_pkg::irq_vector_t irq_ack,
   input wire logic capture_input_pin,
   input wire logic comparator_out,
   output timer0_pkg::irq_vector_t irq_request
);
   import timer0_pkg::*;

   logic [7:0] timer_control_a;
   logic [7:0] irq_enable_mask;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] compare_value_a;
   logic [7:0] compare_value_b;
   logic [7:0] high_hold;
   logic compare_a_flag;
   logic compare_b_flag;
   logic counter_wrap_flag;
   logic capture_event_flag;
   logic block_match;
   logic pin_s1;
   logic pin_s2;
   logic comp_s1;
   logic comp_s2;
   logic raw_in;
   logic filt_out;
   logic filt_last;
   logic edge_prev;
   logic [2:0] filt_cnt;
   logic front;
   logic capture_trigger;
   logic wide;
   logic capture_on;
   logic ctc;
   logic [15:0] count16;
   logic [15:0] next_count;
   logic match_a;
   logic match_b;
   logic at_max;
   logic wr_ctl;
   logic wr_msk;
   logic wr_flg;
   logic wr_cl;
   logic wr_ch;
   logic wr_ca;
   logic wr_cb;
   logic rd_cl;
   logic rd_ca;

   assign wide = timer_control_a[bit_width_select];
   assign capture_on = timer_control_a[bit_capture_mode];
   assign ctc = timer_control_a[bit_clear_on_match];
   assign count16 = {count_high_byte, count_low_byte};
   assign wr_ctl = cpu.wr && cpu.addr == addr_timer_control_a;
   assign wr_msk = cpu.wr && cpu.addr == addr_irq_enable_mask;
   assign wr_flg = cpu.wr && cpu.addr == addr_irq_flag_register;
   assign wr_cl = cpu.wr && cpu.addr == addr_count_low_byte;
   assign wr_ch = cpu.wr && cpu.addr == addr_count_high_byte;
   assign wr_ca = cpu.wr && cpu.addr == addr_compare_value_a;
   assign wr_cb = cpu.wr && cpu.addr == addr_compare_value_b;
   assign rd_cl = cpu.rd && cpu.addr == addr_count_low_byte;
   assign rd_ca = cpu.rd && cpu.addr == addr_compare_value_a;

   // Pin and comparator synchronisers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         comp_s1 <= 1'b0;
         comp_s2 <= 1'b0;
      end else begin
         pin_s1 <= capture_input_pin;
         pin_s2 <= pin_s1;
         comp_s1 <= comparator_out;
         comp_s2 <= comp_s1;
      end
   end

   // R06 comparator source select
   assign raw_in = timer_control_a[bit_comp_source] ? comp_s2 : pin_s2;

   // R03 four sample filter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         filt_out <= 1'b0;
         filt_last <= 1'b0;
         filt_cnt <= 3'h0;
      end else begin
         filt_last <= raw_in;
         if (raw_in != filt_last) begin
            filt_cnt <= 3'h1;
         end else if (filt_cnt < filter_samples) begin
            filt_cnt <= filt_cnt + 3'h1;
         end
         if (raw_in == filt_last && filt_cnt == filter_samples - 3'h1) begin
            filt_out <= raw_in;
         end
      end
   end

   // R03 filter bypass select
   assign front = timer_control_a[bit_noise_filter] ? filt_out : raw_in;

   // R04 edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edge_prev <= 1'b0;
      end else begin
         edge_prev <= front;
      end
   end

   // R04 edge select
   assign capture_trigger = capture_on &&
      (timer_control_a[bit_edge_select] ? (front && !edge_prev) : (!front && edge_prev));

   // R13 R14 comparators
   assign match_a = wide ? (count16 == {compare_value_b, compare_value_a}) : (count_low_byte == compare_value_a);
   assign match_b = !wide && count_low_byte == compare_value_b;
   assign at_max = wide ? (count16 == 16'hFFFF) : (count_low_byte == 8'hFF);

   // R09 R23 count sequence
   always_comb begin
      next_count = count16 + 16'h0001;
      if (ctc && !capture_on && match_a && !block_match) begin
         next_count = 16'h0000;
      end else if (!wide) begin
         next_count = {count_high_byte, 8'(count_low_byte + 8'h01)};
      end
   end

   // R10 R12 R20 counter and byte access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_low_byte <= reset_value;
         count_high_byte <= reset_value;
      end else if (wr_cl) begin
         count_low_byte <= cpu.wdata;
         if (wide) begin
            count_high_byte <= high_hold;
         end
      end else if (wr_ch && !wide) begin
         count_high_byte <= cpu.wdata;
      end else if (timer_tick) begin
         count_low_byte <= next_count[7:0];
         count_high_byte <= next_count[15:8];
      end
   end

   // R11 match blocking after count write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         block_match <= 1'b0;
      end else if (wr_cl || wr_ch) begin
         block_match <= 1'b1;
      end else if (timer_tick) begin
         block_match <= 1'b0;
      end
   end

   // R12 R22 shared high byte holding register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_hold <= reset_value;
      end else if (wr_ch && wide) begin
         high_hold <= cpu.wdata;
      end else if (wr_cb && wide) begin
         high_hold <= cpu.wdata;
      end else if (rd_cl && wide) begin
         high_hold <= count_high_byte;
      end else if (rd_ca && wide && capture_on) begin
         high_hold <= compare_value_b;
      end
   end

   // R01 R02 R05 compare and capture registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         compare_value_a <= reset_value;
         compare_value_b <= reset_value;
      end else if (capture_trigger) begin
         compare_value_a <= count_low_byte;
         compare_value_b <= wide ? count_high_byte : compare_value_b;
      end else if (wr_ca) begin
         compare_value_a <= cpu.wdata;
         if (wide) begin
            compare_value_b <= high_hold;
         end
      end else if (wr_cb && !wide) begin
         compare_value_b <= cpu.wdata;
      end
   end

   // R08 control register with reserved bits zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timer_control_a <= reset_value;
         irq_enable_mask <= reset_value;
      end else begin
         if (wr_ctl) begin
            timer_control_a <= cpu.wdata & control_write_mask;
         end
         if (wr_msk) begin
            irq_enable_mask <= cpu.wdata & mask_write_mask | (irq_enable_mask & ~mask_write_mask);
         end
      end
   end

   // R19 R21 R23 R05 flags, set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         compare_a_flag <= 1'b0;
         compare_b_flag <= 1'b0;
         counter_wrap_flag <= 1'b0;
         capture_event_flag <= 1'b0;
      end else begin
         // R21 compare A flag
         if (timer_tick && match_a && !block_match && !capture_on) begin
            compare_a_flag <= 1'b1;
         end else if (irq_ack.compare_a || (wr_flg && cpu.wdata[bit_irq_compare_a])) begin
            compare_a_flag <= 1'b0;
         end
         // R21 compare B flag
         if (timer_tick && match_b && !block_match && !capture_on) begin
            compare_b_flag <= 1'b1;
         end else if (irq_ack.compare_b || (wr_flg && cpu.wdata[bit_irq_compare_b])) begin
            compare_b_flag <= 1'b0;
         end
         // R17 R23 wrap flag
         if (timer_tick && at_max && !(ctc && !capture_on && match_a && !block_match)) begin
            counter_wrap_flag <= 1'b1;
         end else if (irq_ack.wrap || (wr_flg && cpu.wdata[bit_irq_wrap])) begin
            counter_wrap_flag <= 1'b0;
         end
         // R05 R18 capture flag
         if (capture_trigger) begin
            capture_event_flag <= 1'b1;
         end else if (irq_ack.capture || (wr_flg && cpu.wdata[bit_irq_capture])) begin
            capture_event_flag <= 1'b0;
         end
      end
   end

   // R15 R16 R17 R18 R07 interrupt requests
   always_comb begin
      irq_request.compare_a = global_irq_enable && irq_enable_mask[bit_irq_compare_a] && compare_a_flag;
      irq_request.compare_b = global_irq_enable && irq_enable_mask[bit_irq_compare_b] && compare_b_flag;
      irq_request.wrap = global_irq_enable && irq_enable_mask[bit_irq_wrap] && counter_wrap_flag;
      irq_request.capture = global_irq_enable && irq_enable_mask[bit_irq_capture] && capture_event_flag;
   end

   // R20 R22 read data, count high byte and capture high byte via holding register in 16-bit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= reset_value;
      end else if (cpu.rd) begin
         unique case (cpu.addr)
            addr_timer_control_a: rdata <= timer_control_a;
            addr_irq_enable_mask: rdata <= irq_enable_mask;
            addr_irq_flag_register: rdata <= {3'h0, compare_a_flag, compare_b_flag, 1'b0,
                                              counter_wrap_flag, capture_event_flag};
            addr_count_low_byte: rdata <= count_low_byte;
            addr_count_high_byte: rdata <= wide ? high_hold : count_high_byte;
            addr_compare_value_a: rdata <= compare_value_a;
            addr_compare_value_b: rdata <= (wide && capture_on) ? high_hold : compare_value_b;
            default: rdata <= 8'h00;
         endcase
      end
   end
endmodule : timer0_capture_compare_regs
`default_nettype wire

// *** pkg/timer0_pkg.sv ***
// Package for the timer/counter control and register layer
package timer0_pkg;
   localparam logic [5:0] addr_timer_control_a = 6'h15;
   localparam logic [5:0] addr_irq_enable_mask = 6'h39;
   localparam logic [5:0] addr_irq_flag_register = 6'h38;
   localparam logic [5:0] addr_count_low_byte = 6'h32;
   localparam logic [5:0] addr_count_high_byte = 6'h14;
   localparam logic [5:0] addr_compare_value_a = 6'h13;
   localparam logic [5:0] addr_compare_value_b = 6'h12;
   localparam int bit_width_select = 7;
   localparam int bit_capture_mode = 6;
   localparam int bit_noise_filter = 5;
   localparam int bit_edge_select = 4;
   localparam int bit_comp_source = 3;
   localparam int bit_clear_on_match = 0;
   localparam int bit_irq_compare_a = 4;
   localparam int bit_irq_compare_b = 3;
   localparam int bit_irq_wrap = 1;
   localparam int bit_irq_capture = 0;
   localparam logic [7:0] control_write_mask = 8'hF9;
   localparam logic [7:0] mask_write_mask = 8'h1B;
   localparam logic [7:0] reset_value = 8'h00;
   localparam logic [2:0] filter_samples = 3'h4;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } cpu_access_t;
   typedef struct packed {
      logic compare_a;
      logic compare_b;
      logic wrap;
      logic capture;
   } irq_vector_t;
endpackage : timer0_pkg

// *** testbench/timer0_monitor.sv ***
// Checker for the timer register layer
`timescale 1ns/10ps
`default_nettype none
module timer0_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire timer0_pkg::cpu_access_t cpu,
   input wire logic [7:0] rdata,
   input wire logic timer_tick,
   input wire logic global_irq_enable,
   input wire timer0_pkg::irq_vector_t irq_ack,
   input wire logic capture_input_pin,
   input wire logic comparator_out,
   input wire timer0_pkg::irq_vector_t irq_request
);
   import timer0_pkg::*;
   logic mapped;
   assign mapped = cpu.addr inside {addr_timer_control_a, addr_irq_enable_mask, addr_irq_flag_register,
      addr_count_low_byte, addr_count_high_byte, addr_compare_value_a, addr_compare_value_b};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   irq_gate_a: assert property (!global_irq_enable |-> irq_request == 4'h0)
      else $error("request without global enable");
   read_hold_a: assert property (!cpu.rd |=> $stable(rdata))
      else $error("read data moved without a read");
   unmapped_zero_a: assert property (cpu.rd && !mapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   ctrl_reserved_a: assert property (cpu.rd && cpu.addr == addr_timer_control_a |=> rdata[2:1] == 2'h0)
      else $error("control reserved bits not zero");
   mask_reserved_a: assert property (cpu.rd && cpu.addr == addr_irq_enable_mask |=> (rdata & ~mask_write_mask) == 8'h00)
      else $error("mask reserved bits not zero");
   cmp_after_tick_a: assert property ($rose(irq_request.compare_a) && $stable(global_irq_enable) && !$past(cpu.wr)
      |-> $past(timer_tick))
      else $error("compare flag without timer tick");
   wrap_after_tick_a: assert property ($rose(irq_request.wrap) && $stable(global_irq_enable) && !$past(cpu.wr)
      |-> $past(timer_tick))
      else $error("wrap flag without timer tick");
   cmp_ack_a: assert property (irq_ack.compare_a && !timer_tick |=> !irq_request.compare_a)
      else $error("compare flag kept after vector");
   wrap_ack_a: assert property (irq_ack.wrap && !timer_tick |=> !irq_request.wrap)
      else $error("wrap flag kept after vector");
endmodule : timer0_monitor
bind timer0_capture_compare_regs timer0_monitor u_mon (.clk(clk), .rst(rst), .cpu(cpu), .rdata(rdata),
   .timer_tick(timer_tick), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
   .capture_input_pin(capture_input_pin), .comparator_out(comparator_out), .irq_request(irq_request));
`default_nettype wire

// *** testbench/cpu_vector_model.sv ***
// CPU side model that executes pending interrupt vectors
`timescale 1ns/10ps
`default_nettype none
module cpu_vector_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic vector_on,
   input wire timer0_pkg::irq_vector_t irq_request,
   output var timer0_pkg::irq_vector_t irq_ack
);
   import timer0_pkg::*;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_ack <= '0;
      end else begin
         irq_ack <= vector_on ? irq_vector_t'(irq_request & ~irq_ack) : '0;
      end
   end
endmodule : cpu_vector_model
`default_nettype wire

// *** testbench/timer0_capture_compare_regs_tb.sv ***
// Testbench for the timer register layer
`timescale 1ns/10ps
`default_nettype none
module timer0_capture_compare_regs_tb;
   import timer0_pkg::*;
   logic clk, rst, timer_tick, global_irq_enable, capture_input_pin, comparator_out, vector_on;
   cpu_access_t cpu;
   logic [7:0] rdata;
   irq_vector_t irq_request, irq_ack;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   logic [5:0] addrs [7] = '{addr_timer_control_a, addr_irq_enable_mask, addr_irq_flag_register,
      addr_count_low_byte, addr_count_high_byte, addr_compare_value_a, addr_compare_value_b};
   timer0_capture_compare_regs u_dut (.clk(clk), .rst(rst), .cpu(cpu), .rdata(rdata), .timer_tick(timer_tick),
      .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .capture_input_pin(capture_input_pin),
      .comparator_out(comparator_out), .irq_request(irq_request));
   cpu_vector_model u_cpu (.clk(clk), .rst(rst), .vector_on(vector_on), .irq_request(irq_request),
      .irq_ack(irq_ack));
   task automatic close_out;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      cpu <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      cpu <= '0;
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk);
      cpu <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      cpu <= '0;
      #1 chk(rdata, e);
   endtask : rd
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         timer_tick <= 1'b1;
         @(posedge clk);
         timer_tick <= 1'b0;
      end
   endtask : tick
   task automatic irq(input logic [3:0] e);
      #1 chk({4'h0, irq_request}, {4'h0, e});
   endtask : irq
   task automatic vec;
      @(posedge clk);
      vector_on <= 1'b1;
      repeat (4) @(posedge clk);
      vector_on <= 1'b0;
      irq(4'h0);
   endtask : vec
   task automatic cap(input logic [7:0] c, input logic src, input int w, input logic hi, input logic fin);
      wr(addr_timer_control_a, c);
      wr(addr_irq_flag_register, 8'h01);
      @(posedge clk);
      if (src) begin
         comparator_out <= 1'b1;
      end else begin
         capture_input_pin <= 1'b1;
      end
      repeat (w) @(posedge clk);
      irq({3'h0, hi});
      @(posedge clk);
      comparator_out <= 1'b0;
      capture_input_pin <= 1'b0;
      repeat (12) @(posedge clk);
      irq({3'h0, fin});
   endtask : cap
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         close_out();
      end
   end
   initial begin
      rst = 1'b1;
      cpu = '0;
      timer_tick = 1'b0;
      global_irq_enable = 1'b0;
      capture_input_pin = 1'b0;
      comparator_out = 1'b0;
      vector_on = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (addrs[i]) rd(addrs[i], 8'h00);
      wr(addr_timer_control_a, 8'hFF);
      rd(addr_timer_control_a, 8'hF9);
      wr(addr_irq_enable_mask, 8'hFF);
      rd(addr_irq_enable_mask, 8'h1B);
      wr(6'h3F, 8'h55);
      rd(6'h3F, 8'h00);
      $display("test registers done");
      wr(addr_timer_control_a, 8'h00);
      wr(addr_compare_value_a, 8'h03);
      wr(addr_compare_value_b, 8'h03);
      wr(addr_count_low_byte, 8'h00);
      tick(3);
      irq(4'h0);
      tick(1);
      irq(4'h0);
      @(posedge clk);
      global_irq_enable <= 1'b1;
      irq(4'hC);
      vec();
      wr(addr_count_low_byte, 8'h03);
      tick(1);
      irq(4'h0);
      $display("test compare done");
      wr(addr_timer_control_a, 8'h80);
      wr(addr_count_high_byte, 8'h01);
      wr(addr_count_low_byte, 8'hFF);
      rd(addr_count_low_byte, 8'hFF);
      rd(addr_count_high_byte, 8'h01);
      wr(addr_compare_value_b, 8'h02);
      wr(addr_compare_value_a, 8'h00);
      rd(addr_compare_value_a, 8'h00);
      rd(addr_compare_value_b, 8'h02);
      tick(2);
      irq(4'h8);
      wr(addr_irq_flag_register, 8'h18);
      irq(4'h0);
      $display("test wide done");
      wr(addr_timer_control_a, 8'h01);
      wr(addr_compare_value_a, 8'h02);
      wr(addr_count_low_byte, 8'h00);
      tick(3);
      irq(4'hC);
      rd(addr_count_low_byte, 8'h00);
      wr(addr_irq_flag_register, 8'h1B);
      wr(addr_timer_control_a, 8'h00);
      wr(addr_count_low_byte, 8'hFE);
      tick(2);
      irq(4'h2);
      rd(addr_count_low_byte, 8'h00);
      vec();
      $display("test modes done");
      wr(addr_count_low_byte, 8'h2A);
      cap(8'h50, 1'b0, 3, 1'b1, 1'b1);
      cap(8'h40, 1'b0, 12, 1'b0, 1'b1);
      cap(8'h70, 1'b0, 2, 1'b0, 1'b0);
      cap(8'h70, 1'b0, 6, 1'b0, 1'b1);
      cap(8'h70, 1'b0, 12, 1'b1, 1'b1);
      cap(8'h58, 1'b1, 12, 1'b1, 1'b1);
      cap(8'h50, 1'b1, 12, 1'b0, 1'b0);
      rd(addr_compare_value_a, 8'h2A);
      wr(addr_count_high_byte, 8'h12);
      wr(addr_count_low_byte, 8'h34);
      cap(8'hC0, 1'b0, 12, 1'b0, 1'b1);
      wr(addr_compare_value_b, 8'h77);
      rd(addr_compare_value_b, 8'h77);
      rd(addr_compare_value_a, 8'h34);
      rd(addr_compare_value_b, 8'h12);
      $display("test capture done");
      close_out();
   end
endmodule : timer0_capture_compare_regs_tb
`default_nettype wire
